//--- include/acs_cfg.svh
/*
  Constants of the converter configuration front end: register offsets, field positions,
  reset values and timing figures. Assumes inclusion by bare name from design files only.
*/
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// clock rate and pin timing figures
`define ACS_CLK_MHZ 20
`define ACS_RST_PULSE_NS 10
`define ACS_SEL_SETUP_NS 25

// serial word layout
`define ACS_WORD_BITS 16
`define ACS_NUM_REGS 32

// wishbone byte addresses
`define ACS_WB_CTRL 8'h00
`define ACS_WB_STATUS 8'h04
`define ACS_WB_LAST 8'h08
`define ACS_WB_CFG_BIT 7

// control and status fields
`define ACS_CTRL_SWRST_BIT 0
`define ACS_CTRL_SPDIS_BIT 1
`define ACS_CTRL_RESET 1'b0
`define ACS_STAT_PIN_BIT 0
`define ACS_STAT_FRAME_BIT 1

// internal configuration registers and fields
`define ACS_REG_SWRST 8'h00
`define ACS_REG_PIN 8'h14
`define ACS_REG_FMT 8'h16
`define ACS_RST_BIT 1
`define ACS_OVRD_BIT 7
`define ACS_IF_BIT 5
`define ACS_GAIN_BIT 4
`define ACS_REF_BIT 3
`define ACS_FMT_BIT 4
`define ACS_CFG_DEFAULT 8'h00

`endif

//--- include/acs_pkg.sv
/*
  Types of the converter configuration front end.
  Assumes the constants header is compiled alongside; holds no logic.
*/
package acs_pkg;
  typedef logic [7:0] acs_byte_t;

  // one serial word: address byte first, data byte second
  typedef struct packed {
    acs_byte_t addr;
    acs_byte_t data;
  } acs_word_s;

  // codes of the three mode-select pins, pin 1 as msb
  typedef enum logic [2:0] {
    ACS_PD_NORMAL = 3'b000,
    ACS_PD_A_BUF_OFF = 3'b001,
    ACS_PD_B_BUF_OFF = 3'b010,
    ACS_PD_AB_BUF_OFF = 3'b011,
    ACS_PD_AB_DOWN = 3'b100,
    ACS_PD_A_STANDBY = 3'b101,
    ACS_PD_B_STANDBY = 3'b110,
    ACS_PD_MUX = 3'b111
  } acs_pd_mode_e;
endpackage

//--- include/acs_word_if.sv
/*
  Word carrier between the serial receiver and the register core.
  Assumes both ends run on the same reference clock.
*/
`timescale 1ns/1ps
interface acs_word_if;
  logic word_valid;
  acs_pkg::acs_word_s word;
  logic frame_active;
  logic enable;

  modport rx (output word_valid, output word, output frame_active, input enable);
  modport core (input word_valid, input word, input frame_active, output enable);
endinterface

//--- src/acs_serial_rx.sv
/*
  Three-wire write-only serial receiver, oversampled by the reference clock.
  Assumes shift clock well below half the reference rate; pins are asynchronous.
*/
`timescale 1ns/1ps
`include "acs_cfg.svh"
module acs_serial_rx (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic serial_select_n_i,
  input wire logic shift_clk_i,
  input wire logic serial_input_line_i,
  acs_word_if.rx word_if
);
  localparam logic [3:0] LAST_IDX = 4'(`ACS_WORD_BITS - 1);

  logic [1:0] sel_sync_ff;
  logic [1:0] clk_sync_ff;
  logic [1:0] dat_sync_ff;
  logic clk_d_ff;
  logic [3:0] cnt_ff;
  logic [14:0] shift_ff;
  logic valid_ff;
  acs_pkg::acs_word_s word_ff;

  // two-stage synchronisers; only the second stage is read
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sel_sync_ff <= 2'h3;
      clk_sync_ff <= 2'h0;
      dat_sync_ff <= 2'h0;
      clk_d_ff <= 1'b0; // matches the parked-low shift clock, so no false falling edge after reset
    end else begin
      sel_sync_ff <= {sel_sync_ff[0], serial_select_n_i};
      clk_sync_ff <= {clk_sync_ff[0], shift_clk_i};
      dat_sync_ff <= {dat_sync_ff[0], serial_input_line_i};
      clk_d_ff <= clk_sync_ff[1];
    end
  end

  wire sel_s = sel_sync_ff[1];
  wire clk_s = clk_sync_ff[1];
  wire dat_s = dat_sync_ff[1];
  // shifting only while select is low and the port is enabled
  wire active = ~sel_s & word_if.enable;
  // data taken on each falling shift-clock edge
  wire take = active & clk_d_ff & ~clk_s;
  wire last_bit = take & (cnt_ff == LAST_IDX);
  // select high restarts the count, dropping a partial word
  wire [3:0] nxt_cnt = ~active ? 4'h0 : (take ? 4'(cnt_ff + 4'h1) : cnt_ff);
  wire [14:0] nxt_shift = take ? {shift_ff[13:0], dat_s} : shift_ff;

  // word assembly, msb first, so the address byte arrives first
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ff <= 4'h0;
      shift_ff <= 15'h0000;
      valid_ff <= 1'b0;
      word_ff <= 16'h0000;
    end else begin
      cnt_ff <= nxt_cnt;
      shift_ff <= nxt_shift;
      valid_ff <= last_bit;
      word_ff <= last_bit ? {shift_ff, dat_s} : word_ff;
    end
  end

  assign word_if.word_valid = valid_ff;
  assign word_if.word = word_ff;
  assign word_if.frame_active = active;

  a_idle_ignore: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sel_s |=> !valid_ff && cnt_ff == 4'h0) else $error("word or count while select high");
  a_commit_sixteen: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    valid_ff |-> $past(take) && $past(cnt_ff) == 4'hF) else $error("word without sixteenth edge");
  a_restart_count: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(sel_s) |=> cnt_ff == 4'h0 ##1 !valid_ff) else $error("partial word kept");
  a_addr_first: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    last_bit |=> word_ff.addr == $past(shift_ff[14:7])) else $error("address byte misplaced");
endmodule

//--- src/acs_config_top.sv
/*
  Configuration front end of a dual-channel converter: serial register writes,
  hardware and software register reset, parallel pin decode and a Wishbone slave.
  Assumes classic Wishbone on the reference clock; all other pins are asynchronous.
*/
`timescale 1ns/1ps
`include "acs_cfg.svh"
// Operation
// - Serial bits shift in only while select is low.
// - Each data bit is sampled on a falling shift-clock edge.
// - Every sixteenth falling edge commits the word to its register.
// - Trailing bits short of a full word are dropped.
// - Several words may follow inside one select pulse.
// - First byte is the register address, second byte the data.
// - A high pulse on the reset pin restores all register defaults.
// - Writing the software reset bit loads defaults and clears itself.
// - Pin mode: shift-clock level picks gain and reference.
// - Pin mode: select level picks data format and output interface.
// - Mode codes 000 to 011 control the output buffers.
// - Mode codes 100 to 110 power down or put channels in standby.
// - Mode code 111 selects multiplexed output, valid with CMOS only.
// - Override bit zero lets pins govern power-down, one lets registers.
module acs_config_top (
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CFG_RESET_I,
  input wire logic SERIAL_SELECT_N_I,
  input wire logic SHIFT_CLK_I,
  input wire logic SERIAL_INPUT_LINE_I,
  input wire logic [1:0] SHIFT_CLK_LEVEL_I,
  input wire logic [1:0] SELECT_LEVEL_I,
  input wire logic MODE_SELECT_PIN_1_I,
  input wire logic MODE_SELECT_PIN_2_I,
  input wire logic MODE_SELECT_PIN_3_I,
  output logic GAIN_3P5DB_O,
  output logic EXT_REF_O,
  output logic OFFSET_BINARY_O,
  output logic CMOS_OUT_O,
  output logic CHA_BUF_OFF_O,
  output logic CHB_BUF_OFF_O,
  output logic BOTH_POWER_DOWN_O,
  output logic CHA_STANDBY_O,
  output logic CHB_STANDBY_O,
  output logic MUX_MODE_O,
  output logic PIN_MODE_O
);
  // least reset pulse in cycles, rounded up, never below one
  localparam int RST_PULSE_RAW = (`ACS_RST_PULSE_NS * `ACS_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] RST_PULSE_CYC = 4'((RST_PULSE_RAW < 1) ? 1 : RST_PULSE_RAW);
  localparam logic [4:0] IDX_SWRST = 5'(`ACS_REG_SWRST);
  localparam logic [4:0] IDX_PIN = 5'(`ACS_REG_PIN);
  localparam logic [4:0] IDX_FMT = 5'(`ACS_REG_FMT);

  acs_word_if word_if ();

  // serial receiver; it owns the serial pin synchronisers
  acs_serial_rx u_rx (
    .clk_i(REF_CLK_I),
    .rst_b_i(RST_B_I),
    .serial_select_n_i(SERIAL_SELECT_N_I),
    .shift_clk_i(SHIFT_CLK_I),
    .serial_input_line_i(SERIAL_INPUT_LINE_I),
    .word_if(word_if)
  );

  logic [1:0] rst_sync_ff;
  logic [1:0] clk_lvl_sync_ff [2];
  logic [1:0] sel_lvl_sync_ff [2];
  logic [2:0] mode_sync_ff [2];
  logic [3:0] rst_cnt_ff;
  logic [7:0] cfg_ff [`ACS_NUM_REGS];
  logic spdis_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;
  logic [7:0] commit_cnt_ff;
  acs_pkg::acs_word_s last_ff;

  // static pins pass two flops before any decode
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_sync_ff <= 2'h0;
      clk_lvl_sync_ff[0] <= 2'h0;
      clk_lvl_sync_ff[1] <= 2'h0;
      sel_lvl_sync_ff[0] <= 2'h0;
      sel_lvl_sync_ff[1] <= 2'h0;
      mode_sync_ff[0] <= 3'h0;
      mode_sync_ff[1] <= 3'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], CFG_RESET_I};
      clk_lvl_sync_ff[0] <= SHIFT_CLK_LEVEL_I;
      clk_lvl_sync_ff[1] <= clk_lvl_sync_ff[0];
      sel_lvl_sync_ff[0] <= SELECT_LEVEL_I;
      sel_lvl_sync_ff[1] <= sel_lvl_sync_ff[0];
      mode_sync_ff[0] <= {MODE_SELECT_PIN_1_I, MODE_SELECT_PIN_2_I, MODE_SELECT_PIN_3_I};
      mode_sync_ff[1] <= mode_sync_ff[0];
    end
  end

  wire rst_s = rst_sync_ff[1];
  wire [1:0] clk_lvl_s = clk_lvl_sync_ff[1];
  wire [1:0] sel_lvl_s = sel_lvl_sync_ff[1];
  wire [2:0] pin_code_s = mode_sync_ff[1];

  // reset pin width check; a pulse shorter than one clock period may be missed
  wire [3:0] nxt_rst_cnt = ~rst_s ? 4'h0 : ((rst_cnt_ff == 4'hF) ? rst_cnt_ff : 4'(rst_cnt_ff + 4'h1));
  wire hw_rst = rst_s & (rst_cnt_ff >= 4'(RST_PULSE_CYC - 4'h1));

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_cnt_ff <= 4'h0;
    end else begin
      rst_cnt_ff <= nxt_rst_cnt;
    end
  end

  // a held-high reset pin is pin-only mode; serial is refused there
  wire pin_mode = rst_s;
  assign word_if.enable = ~pin_mode & ~spdis_ff;

  // wishbone decode; one request per ack, ack drops the cycle after it rose
  wire wb_req = WB_CYC_I & WB_STB_I & ~ack_ff;
  wire wb_wr = wb_req & WB_WE_I & WB_SEL_I[0];
  wire hit_ctrl = (WB_ADR_I == `ACS_WB_CTRL);
  wire hit_stat = (WB_ADR_I == `ACS_WB_STATUS);
  wire hit_last = (WB_ADR_I == `ACS_WB_LAST);
  wire hit_cfg = WB_ADR_I[`ACS_WB_CFG_BIT] & (WB_ADR_I[1:0] == 2'h0);
  wire [4:0] wb_idx = WB_ADR_I[6:2];
  wire wb_cfg_wr = wb_wr & hit_cfg;
  wire wb_ctrl_wr = wb_wr & hit_ctrl;

  // serial commits reach only the implemented register range
  wire [7:0] ser_addr = word_if.word.addr;
  wire [7:0] ser_data = word_if.word.data;
  wire ser_wr = word_if.word_valid & (ser_addr[7:5] == 3'h0);
  wire [4:0] ser_idx = ser_addr[4:0];

  // software reset from the serial port, the register window or the control word
  wire ser_swrst = ser_wr & (ser_idx == IDX_SWRST) & ser_data[`ACS_RST_BIT];
  wire wb_cfg_swrst = wb_cfg_wr & (wb_idx == IDX_SWRST) & WB_DAT_I[`ACS_RST_BIT];
  wire wb_ctl_swrst = wb_ctrl_wr & WB_DAT_I[`ACS_CTRL_SWRST_BIT];
  wire sw_rst = ser_swrst | wb_cfg_swrst | wb_ctl_swrst;
  wire load_dflt = hw_rst | sw_rst;

  // register file; defaults win, then serial, then the bus, so a serial word is lost to a same-cycle bus write only if it is a software reset
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      for (int i = 0; i < `ACS_NUM_REGS; i++) begin
        cfg_ff[i] <= `ACS_CFG_DEFAULT;
      end
    end else begin
      for (int i = 0; i < `ACS_NUM_REGS; i++) begin
        if (load_dflt) begin
          cfg_ff[i] <= `ACS_CFG_DEFAULT;
        end else if (ser_wr && ser_idx == 5'(i)) begin
          cfg_ff[i] <= ser_data;
        end else if (wb_cfg_wr && wb_idx == 5'(i)) begin
          cfg_ff[i] <= WB_DAT_I[7:0];
        end
      end
    end
  end

  // bookkeeping of serial commits for software
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      commit_cnt_ff <= 8'h00;
      last_ff <= 16'h0000;
    end else if (word_if.word_valid) begin
      commit_cnt_ff <= 8'(commit_cnt_ff + 8'h01);
      last_ff <= word_if.word;
    end
  end

  // read selection; unmapped addresses answer zero with a normal ack
  wire [31:0] stat_word = {16'h0000, commit_cnt_ff, 6'h00, word_if.frame_active, pin_mode};
  wire [31:0] ctrl_word = {30'h0, spdis_ff, 1'b0};
  wire [31:0] rd_sel = hit_ctrl ? ctrl_word :
                       hit_stat ? stat_word :
                       hit_last ? {16'h0000, last_ff} :
                       hit_cfg ? {24'h000000, cfg_ff[wb_idx]} : 32'h00000000;

  // bus slave flops; the swrst control bit is a pulse and reads zero
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
      spdis_ff <= `ACS_CTRL_RESET;
    end else begin
      ack_ff <= wb_req;
      rdat_ff <= wb_req ? rd_sel : rdat_ff;
      spdis_ff <= wb_ctrl_wr ? WB_DAT_I[`ACS_CTRL_SPDIS_BIT] : spdis_ff;
    end
  end

  assign WB_ACK_O = ack_ff;
  assign WB_DAT_O = rdat_ff;

  // serial-mode settings; the override bit hands power-down to the register
  wire [7:0] reg_pin = cfg_ff[IDX_PIN];
  wire [7:0] reg_fmt = cfg_ff[IDX_FMT];
  wire ovrd_eff = ~pin_mode & reg_pin[`ACS_OVRD_BIT];
  wire [2:0] pd_code = ovrd_eff ? reg_pin[2:0] : pin_code_s;
  wire cmos_sel = pin_mode ? sel_lvl_s[1] : reg_pin[`ACS_IF_BIT];
  // levels 00,01,10,11 read as 0, 3/8, 5/8 and full supply
  wire gain_sel = pin_mode ? clk_lvl_s[1] : reg_pin[`ACS_GAIN_BIT];
  wire ext_sel = pin_mode ? (clk_lvl_s[1] ^ clk_lvl_s[0]) : reg_pin[`ACS_REF_BIT];
  wire obin_sel = pin_mode ? (sel_lvl_s[1] ^ sel_lvl_s[0]) : reg_fmt[`ACS_FMT_BIT];

  acs_pkg::acs_pd_mode_e pd_mode;
  assign pd_mode = acs_pkg::acs_pd_mode_e'(pd_code);
  logic a_buf;
  logic b_buf;
  logic ab_down;
  logic a_stby;
  logic b_stby;
  logic mux_req;

  // power-down decode; every code is legal so no default
  always_comb begin
    a_buf = 1'b0;
    b_buf = 1'b0;
    ab_down = 1'b0;
    a_stby = 1'b0;
    b_stby = 1'b0;
    mux_req = 1'b0;
    unique case (pd_mode)
      acs_pkg::ACS_PD_NORMAL: a_buf = 1'b0;
      acs_pkg::ACS_PD_A_BUF_OFF: a_buf = 1'b1;
      acs_pkg::ACS_PD_B_BUF_OFF: b_buf = 1'b1;
      acs_pkg::ACS_PD_AB_BUF_OFF: begin
        a_buf = 1'b1;
        b_buf = 1'b1;
      end
      acs_pkg::ACS_PD_AB_DOWN: ab_down = 1'b1;
      acs_pkg::ACS_PD_A_STANDBY: a_stby = 1'b1;
      acs_pkg::ACS_PD_B_STANDBY: b_stby = 1'b1;
      acs_pkg::ACS_PD_MUX: mux_req = 1'b1;
    endcase
  end

  // outputs are registered so the analog side never sees decode glitches
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      GAIN_3P5DB_O <= 1'b0;
      EXT_REF_O <= 1'b0;
      OFFSET_BINARY_O <= 1'b0;
      CMOS_OUT_O <= 1'b0;
      CHA_BUF_OFF_O <= 1'b0;
      CHB_BUF_OFF_O <= 1'b0;
      BOTH_POWER_DOWN_O <= 1'b0;
      CHA_STANDBY_O <= 1'b0;
      CHB_STANDBY_O <= 1'b0;
      MUX_MODE_O <= 1'b0;
      PIN_MODE_O <= 1'b0;
    end else begin
      GAIN_3P5DB_O <= gain_sel;
      EXT_REF_O <= ext_sel;
      OFFSET_BINARY_O <= obin_sel;
      CMOS_OUT_O <= cmos_sel;
      CHA_BUF_OFF_O <= a_buf;
      CHB_BUF_OFF_O <= b_buf;
      BOTH_POWER_DOWN_O <= ab_down;
      CHA_STANDBY_O <= a_stby;
      CHB_STANDBY_O <= b_stby;
      MUX_MODE_O <= mux_req & cmos_sel;
      PIN_MODE_O <= pin_mode;
    end
  end

  a_hw_rst_dflt: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    hw_rst |=> cfg_ff[IDX_PIN] == `ACS_CFG_DEFAULT && cfg_ff[IDX_FMT] == `ACS_CFG_DEFAULT)
    else $error("hardware reset left a register set");
  a_sw_rst_clear: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    ser_swrst |=> !cfg_ff[IDX_SWRST][`ACS_RST_BIT] && cfg_ff[IDX_PIN] == `ACS_CFG_DEFAULT)
    else $error("software reset did not clear");
  a_word_commit: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (ser_wr && !load_dflt) |=> cfg_ff[$past(ser_idx)] == $past(ser_data))
    else $error("serial word not committed");
  a_gain_decode: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    pin_mode |=> GAIN_3P5DB_O == $past(clk_lvl_s[1]) && EXT_REF_O == $past(^clk_lvl_s))
    else $error("gain or reference decode wrong");
  a_fmt_decode: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    pin_mode |=> CMOS_OUT_O == $past(sel_lvl_s[1]) && OFFSET_BINARY_O == $past(^sel_lvl_s))
    else $error("format or interface decode wrong");
  a_pins_powerdown: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (!ovrd_eff && pin_code_s == 3'b100) |=> BOTH_POWER_DOWN_O && !CHA_STANDBY_O && !CHA_BUF_OFF_O)
    else $error("pin power-down decode wrong");
  a_pins_buffers: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (!ovrd_eff && pin_code_s == 3'b011) |=> CHA_BUF_OFF_O && CHB_BUF_OFF_O && !BOTH_POWER_DOWN_O)
    else $error("pin buffer decode wrong");
  a_reg_override: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (ovrd_eff && reg_pin[2:0] == 3'b101) |=> CHA_STANDBY_O && !CHB_STANDBY_O)
    else $error("override bit ignored");
  a_mux_cmos: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    MUX_MODE_O |-> CMOS_OUT_O && $past(pd_code) == 3'b111)
    else $error("mux mode without cmos");
  a_ack_single: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    ack_ff |=> !ack_ff) else $error("ack held two cycles");

  // answer timing, serial gating and flag in pin mode, bus software reset and the remaining power codes
  a_ack_answer: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    wb_req |=> WB_ACK_O)
    else $error("request not answered");
  a_pin_no_serial: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    pin_mode |-> !word_if.enable)
    else $error("serial port open in pin mode");
  a_pin_mode_out: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    pin_mode |=> PIN_MODE_O)
    else $error("pin mode not flagged");
  a_bus_sw_rst: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (wb_cfg_swrst || wb_ctl_swrst) |=> !cfg_ff[IDX_SWRST][`ACS_RST_BIT] && cfg_ff[IDX_PIN] == `ACS_CFG_DEFAULT)
    else $error("bus software reset did not clear");
  a_pins_normal: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (!ovrd_eff && pin_code_s == 3'b000) |=> !CHA_BUF_OFF_O && !CHB_BUF_OFF_O && !BOTH_POWER_DOWN_O && !MUX_MODE_O)
    else $error("normal code not normal");
  a_pins_buf_a: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (!ovrd_eff && pin_code_s == 3'b001) |=> CHA_BUF_OFF_O && !CHB_BUF_OFF_O)
    else $error("channel a buffer decode wrong");
  a_pins_buf_b: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (!ovrd_eff && pin_code_s == 3'b010) |=> CHB_BUF_OFF_O && !CHA_BUF_OFF_O)
    else $error("channel b buffer decode wrong");
  a_pins_stby_b: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (!ovrd_eff && pin_code_s == 3'b110) |=> CHB_STANDBY_O && !CHA_STANDBY_O && !BOTH_POWER_DOWN_O)
    else $error("channel b standby decode wrong");
  a_mux_request: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (pd_code == 3'b111 && cmos_sel) |=> MUX_MODE_O)
    else $error("mux mode not entered");
  a_mux_lvds_off: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (pd_code == 3'b111 && !cmos_sel) |=> !MUX_MODE_O)
    else $error("mux mode with lvds");
endmodule

//--- sim/acs_host_model.sv
/*
  host-side model of the three-wire write-only serial port: frames words msb first.
  assumes the caller waits for reset release; pins are unrelated in phase to the reference clock.
*/
`timescale 1ns/1ps
module acs_host_model (
  output logic sel_n_o,
  output logic shift_clk_o,
  output logic data_o
);
  // idle: select high, clock parked low, data line idle
  initial begin
    sel_n_o = 1'b1;
    shift_clk_o = 1'b0;
    data_o = 1'b0;
  end

  // one select period with n bits; several whole words may share it
  task automatic send(input logic [63:0] bits, input int n);
    #37;
    sel_n_o = 1'b0; // long setup after select falls and before first edge
    #200;
    for (int i = n - 1; i >= 0; i--) begin
      data_o = bits[i]; // change on the rising edge, stable across the falling one
      shift_clk_o = 1'b1;
      #200;
      shift_clk_o = 1'b0; // 400 ns period keeps the rate far below the limit
      #200;
    end
    data_o = ~data_o; // hold time over: no stale level left on the line
    #100;
    sel_n_o = 1'b1;
    #200;
  endtask

  // clock and data activity with select high, which the device must ignore
  task automatic noise(input int n);
    #13; // keeps pin changes off the reference clock edges
    for (int i = 0; i < n; i++) begin
      data_o = 1'($urandom);
      shift_clk_o = 1'b1;
      #200;
      shift_clk_o = 1'b0;
      #200;
    end
  endtask
endmodule

//--- sim/adc_config_serial_and_pin_control_tb.sv
/*
  self-checking bench of the configuration front end: serial words, resets, pin decode.
  assumes the host model drives the serial pins and registers are read back over wishbone.
*/
`timescale 1ns/1ps
`define CHK(got, want) begin total_checks++; if ((got) !== (want)) begin failures++; \
  $display("unexpected at %0t: got %0h want %0h", $time, got, want); end end
module adc_config_serial_and_pin_control_tb;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, cfg_rst = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, q, st0;
  logic [1:0] sclk_lvl = 2'h0, sel_lvl = 2'h0;
  logic [2:0] mode = 3'h0; // mode pins grounded while serial-only
  wire logic sel_n, sclk, serial_input_line, ack;
  wire logic [31:0] dat_o;
  wire logic [10:0] outs; // gain ext off cmos abuf bbuf both asb bsb mux pin
  logic [7:0] exp_reg [32];
  logic [7:0] a1, d1, a2, d2;
  int failures = 0, total_checks = 0, cycles = 0;

  always #25 ref_clk = ~ref_clk;

  acs_host_model host (.sel_n_o(sel_n), .shift_clk_o(sclk), .data_o(serial_input_line));

  acs_config_top dut (.REF_CLK_I(ref_clk), .RST_B_I(rst_b), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .CFG_RESET_I(cfg_rst), .SERIAL_SELECT_N_I(sel_n), .SHIFT_CLK_I(sclk), .SERIAL_INPUT_LINE_I(serial_input_line),
    .SHIFT_CLK_LEVEL_I(sclk_lvl), .SELECT_LEVEL_I(sel_lvl), .MODE_SELECT_PIN_1_I(mode[2]),
    .MODE_SELECT_PIN_2_I(mode[1]), .MODE_SELECT_PIN_3_I(mode[0]), .GAIN_3P5DB_O(outs[10]),
    .EXT_REF_O(outs[9]), .OFFSET_BINARY_O(outs[8]), .CMOS_OUT_O(outs[7]), .CHA_BUF_OFF_O(outs[6]),
    .CHB_BUF_OFF_O(outs[5]), .BOTH_POWER_DOWN_O(outs[4]), .CHA_STANDBY_O(outs[3]),
    .CHB_STANDBY_O(outs[2]), .MUX_MODE_O(outs[1]), .PIN_MODE_O(outs[0]));

  // expected outputs in pin-only mode from the two analog levels and the mode code
  function automatic logic [10:0] pin_exp(input logic [1:0] s, input logic [1:0] e, input logic [2:0] m);
    logic cm;
    cm = e[1];
    return {s[1], s[1] ^ s[0], e[1] ^ e[0], cm, m == 3'b001 || m == 3'b011, m == 3'b010 || m == 3'b011,
      m == 3'b100, m == 3'b101, m == 3'b110, m == 3'b111 && cm, 1'b1};
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // hang guard: the whole run needs well under this many cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles > 40000) begin
      $display("unexpected at %0t: run timeout", $time);
      failures++;
      conclude();
    end
  end

  // classic single cycle; held until ack is sampled high at an edge, released at that edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) begin
      $display("unexpected at %0t: no bus answer", $time);
      failures++;
      conclude();
    end
    r = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic chk_all();
    for (int i = 0; i < 32; i++) begin
      wb(1'b0, 8'h80 + 8'(4 * i), 32'h0, q);
      `CHK(q[7:0], exp_reg[i])
    end
  endtask

  task automatic frame(input logic [63:0] b, input int n);
    host.send(b, n);
    repeat (12) @(posedge ref_clk);
  endtask

  task automatic hw_reset();
    @(posedge ref_clk);
    cfg_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    cfg_rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    foreach (exp_reg[i]) exp_reg[i] = 8'h00;
  endtask

  initial begin
    void'($urandom(32'hdabee7f1));
    repeat (3) @(posedge ref_clk); // supplies taken as settled; pulse only after this wait
    rst_b <= 1'b1;
    hw_reset(); // registers initialised before any use
    chk_all();
    `CHK(outs, 11'h000)
    wb(1'b0, 8'h0C, 32'h0, q);
    `CHK(q, 32'h0)
    // single random words, each in its own select period
    for (int k = 0; k < 6; k++) begin
      a1 = 8'($urandom_range(31, 1));
      d1 = 8'($urandom);
      exp_reg[a1] = d1;
      frame({48'h0, a1, d1}, 16);
      wb(1'b0, a1 * 8'h04 + 8'h80, 32'h0, q);
      `CHK(q[7:0], d1)
      wb(1'b0, 8'h08, 32'h0, q);
      `CHK(q[15:0], {a1, d1})
    end
    // two words and five loose bits in one select period
    wb(1'b0, 8'h04, 32'h0, st0);
    a1 = 8'($urandom_range(31, 1));
    a2 = 8'(a1 % 31) + 8'h01;
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    exp_reg[a1] = d1;
    exp_reg[a2] = d2;
    frame({27'h0, a1, d1, a2, d2, 5'b10110}, 37);
    wb(1'b0, 8'h04, 32'h0, q);
    `CHK(q[15:8], st0[15:8] + 8'h02)
    wb(1'b0, 8'h08, 32'h0, q);
    `CHK(q[15:0], {a2, d2})
    chk_all();
    // activity with select high leaves everything alone
    host.noise(20);
    repeat (12) @(posedge ref_clk);
    wb(1'b0, 8'h04, 32'h0, q);
    `CHK(q[15:8], st0[15:8] + 8'h02)
    `CHK(q[1:0], 2'h0)
    chk_all();
    // software reset through the serial port clears all and itself
    frame({48'h0, 8'h00, 8'h02}, 16);
    foreach (exp_reg[i]) exp_reg[i] = 8'h00;
    chk_all();
    // bus path: window write, window reset, serial disable, control reset
    a1 = 8'($urandom_range(31, 1));
    d1 = 8'($urandom_range(255, 1));
    wb(1'b1, a1 * 8'h04 + 8'h80, {24'h0, d1}, q);
    wb(1'b0, a1 * 8'h04 + 8'h80, 32'h0, q);
    `CHK(q[7:0], d1)
    wb(1'b1, 8'h80, 32'h2, q);
    wb(1'b0, a1 * 8'h04 + 8'h80, 32'h0, q);
    `CHK(q[7:0], 8'h00)
    wb(1'b1, 8'h00, 32'h2, q);
    wb(1'b0, 8'h00, 32'h0, q);
    `CHK(q[1:0], 2'h2)
    frame({48'h0, a1, d1}, 16);
    wb(1'b0, a1 * 8'h04 + 8'h80, 32'h0, q);
    `CHK(q[7:0], 8'h00)
    wb(1'b1, a1 * 8'h04 + 8'h80, {24'h0, d1}, q);
    wb(1'b1, 8'h00, 32'h1, q);
    wb(1'b0, a1 * 8'h04 + 8'h80, 32'h0, q);
    `CHK(q[7:0], 8'h00)
    wb(1'b0, 8'h00, 32'h0, q);
    `CHK(q[1:0], 2'h0)
    // override bit decides between pins and register power code
    @(posedge ref_clk);
    mode <= 3'b100;
    repeat (6) @(posedge ref_clk);
    `CHK(outs, 11'h010)
    frame({48'h0, 8'h14, 8'hA5}, 16);
    `CHK(outs, 11'b000_1000_1000)
    hw_reset();
    `CHK(outs, 11'h010)
    wb(1'b0, 8'hD0, 32'h0, q);
    `CHK(q[7:0], 8'h00)
    // pin-only mode: every mode code against every level
    @(posedge ref_clk);
    cfg_rst <= 1'b1; // reset pin held high from here on: pin-only mode
    for (int m = 0; m < 8; m++) begin
      for (int k = 0; k < 4; k++) begin
        @(posedge ref_clk);
        mode <= 3'(m);
        sclk_lvl <= 2'(k);
        sel_lvl <= 2'(k + m);
        repeat (6) @(posedge ref_clk);
        `CHK(outs, pin_exp(2'(k), 2'(k + m), 3'(m)))
      end
    end
    wb(1'b0, 8'h04, 32'h0, q);
    `CHK(q[1:0], 2'h1)
    conclude();
  end
endmodule
